// [rtl/sts_ms_tick.sv]
`timescale 1ns/1ns
// millisecond enable divider
// assumes one aclk domain, synchronous active low reset
module sts_ms_tick #(
    parameter int CYCLES = 100_000
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick
);
    import sts_pkg::*;
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } sts_tick_st_t;
    sts_tick_st_t s_q, s_d;
    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 32'(CYCLES - 1))
        begin
            s_d.cnt = 32'h0000_0000;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end
    assign tick = s_q.tick;
endmodule

// [rtl/sts_pkg.sv]
// package of constants and carriers for the scan trigger sequencer
// assumes a 100 MHz aclk and an axi4-lite master on the register side
// Function
// - level trigger: laser and read start as soon as trigger goes active
// - laser stops when decodes reach match count, then read data is sent; sent only if tx_busy is low at the result, else dropped
// - gain settling of up to three scans, 6 ms, precedes any decode
// - pass and fail output width configurable from 10 ms to 2.55 s
// - result output asserted 5 ms after a successful read completes
// - no decode: fail output after 5 ms plus configured trigger input time
// - triggers ignored for 5 s after power-up or unlock command
// - test switch press under 2 s acts as one trigger
// - pulse trigger: read for the window, stop early on match count
// - pulse trigger: laser starts only after trigger held past input time
// - single label mode: at most one bar code per trigger
// - output-on-decode: data and result right after successful read; here both are given only after the 5 ms result delay
// - deferred: output at trigger release or window expiry
// - up to four configured code types decoded without reconfiguration
// - transmit time is bits per character over baud times characters
package sts_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_CYC = CLK_HZ / 1000;
    localparam int SETTLE_MS = 6;
    localparam int SETTLE_CYC = SETTLE_MS * MS_CYC;
    localparam int RESULT_DLY_MS = 5;
    localparam int RESULT_DLY_CYC = RESULT_DLY_MS * MS_CYC;
    localparam int LOCKOUT_MS = 5000;
    localparam int TEST_MAX_MS = 2000;
    localparam int OUT_STEP_MS = 10;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MATCH = 8'h04;
    localparam logic [7:0] REG_TRIG_TIME = 8'h08;
    localparam logic [7:0] REG_WINDOW = 8'h0C;
    localparam logic [7:0] REG_OUT_WIDTH = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_IRQ_STAT = 8'h18;
    localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
    localparam logic [7:0] REG_CMD = 8'h20;
    localparam logic [7:0] REG_RESULT = 8'h24;
    localparam logic [7:0] REG_TX_TIME = 8'h28;
    localparam logic [7:0] REG_SERIAL = 8'h2C;
    localparam logic [7:0] RST_MATCH = 8'h01;
    localparam logic [7:0] RST_TRIG_TIME = 8'h02;
    localparam logic [15:0] RST_WINDOW = 16'h0064;
    localparam logic [7:0] RST_OUT_WIDTH = 8'h0A;
    localparam logic [3:0] RST_CODE_EN = 4'h1;
    localparam int IRQ_PASS = 0;
    localparam int IRQ_FAIL = 1;
    localparam int IRQ_TX = 2;
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic pulse_mode;
        logic deferred;
        logic [3:0] code_en;
        logic [7:0] match;
        logic [7:0] trig_ms;
        logic [15:0] window_ms;
        logic [7:0] out_width;
        logic [3:0] data_bits;
        logic parity;
        logic [7:0] chars;
        logic [15:0] baud_div;
    } sts_cfg_t;

    typedef struct packed {
        logic valid;
        logic [1:0] code_type;
        logic [31:0] data;
    } sts_decode_t;
endpackage

// [rtl/sts_sequencer.sv]
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
// scan trigger sequencer: trigger, gain settling, decode count, result timing
// assumes an axi4-lite master, an external decoder and serial transmitter
module sts_sequencer #(
    parameter int MS_CYCLES = sts_pkg::MS_CYC,
    parameter int LOCKOUT_MS_P = sts_pkg::LOCKOUT_MS,
    parameter int SETTLE_CYC_P = sts_pkg::SETTLE_CYC,
    parameter int RESULT_DLY_P = sts_pkg::RESULT_DLY_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trigger_in,
    input wire logic test_switch_n,
    input wire sts_pkg::sts_decode_t decode_in,
    output logic laser_on,
    output logic decode_enable,
    output logic read_pass_output,
    output logic read_fail_output,
    output logic tx_start,
    output logic [31:0] tx_data,
    input wire logic tx_busy,
    output logic irq
);
    import sts_pkg::*;

    typedef enum logic [2:0] {IDLE, ARM, SETTLE, READ, HOLD, DELAY, SEND} sts_state_t;

    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        sts_cfg_t cfg;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic irq;
        logic [2:0] trig_sync;
        logic trig;
        logic [2:0] test_sync;
        logic test;
        logic [15:0] test_ms;
        logic test_fire;
        logic trig_prev;
        logic by_test;
        logic [15:0] lock_ms;
        sts_state_t state;
        logic [31:0] cyc;
        logic [15:0] ms;
        logic [7:0] hits;
        logic [31:0] data;
        logic passed;
        logic laser;
        logic dec_en;
        logic pass_o;
        logic fail_o;
        logic [7:0] out_ms;
        logic tx_start;
        logic [31:0] tx_data;
        logic [31:0] tx_time;
    } sts_st_t;

    sts_st_t s_q, s_d;
    logic ms_tick;
    logic trig_go;
    logic trig_src;

    sts_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(ms_tick)
    );

    // byte-lane merge used by every writable register except REG_CMD and REG_IRQ_STAT
    function automatic logic [31:0] sts_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        return (a <= REG_SERIAL) && (a[1:0] == 2'b00);
    endfunction

    assign trig_src = s_q.trig | s_q.test_fire;
    // edge, not level: a trigger still held after the result must not start a second read
    assign trig_go = ((s_q.trig && !s_q.trig_prev) || s_q.test_fire) && (s_q.lock_ms == 16'h0000);

    always_comb
    begin
        logic [31:0] w;
        logic [31:0] rd;
        logic wr;
        w = '0;
        rd = '0;
        s_d = s_q;
        s_d.tx_start = 1'b0;
        s_d.test_fire = 1'b0;
        // ------------------------------------------------------------
        // pin synchronisers: change counts once stages two and three agree
        // ------------------------------------------------------------
        s_d.trig_prev = s_q.trig;
        s_d.trig_sync = {s_q.trig_sync[1:0], trigger_in};
        if (s_q.trig_sync[1] == s_q.trig_sync[2])
            s_d.trig = s_q.trig_sync[2];
        s_d.test_sync = {s_q.test_sync[1:0], ~test_switch_n};
        if (s_q.test_sync[1] == s_q.test_sync[2])
            s_d.test = s_q.test_sync[2];
        // short press only; a long press is left for other test modes
        if (s_q.test && ms_tick && s_q.test_ms != 16'hFFFF)
            s_d.test_ms = s_q.test_ms + 16'h0001;
        if (!s_q.test)
            s_d.test_ms = 16'h0000;
        if (s_q.test && !s_d.test && s_q.test_ms < 16'(TEST_MAX_MS))
            s_d.test_fire = 1'b1;
        if (ms_tick && s_q.lock_ms != 16'h0000)
            s_d.lock_ms = s_q.lock_ms - 16'h0001;
        // ------------------------------------------------------------
        // axi4-lite slave
        // ------------------------------------------------------------
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;
        wr = s_q.aw_got && s_q.w_got && !s_q.bvalid;
        if (wr)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = known_addr(s_q.awaddr) ? RESP_OK : RESP_SLVERR;
            unique case (s_q.awaddr)
                REG_CTRL:
                begin
                    w = sts_merge({26'h0, s_q.cfg.code_en, s_q.cfg.deferred, s_q.cfg.pulse_mode},
                        s_q.wdata, s_q.wstrb);
                    s_d.cfg.pulse_mode = w[0];
                    s_d.cfg.deferred = w[1];
                    s_d.cfg.code_en = w[5:2];
                end
                REG_MATCH:
                begin
                    w = sts_merge({24'h0, s_q.cfg.match}, s_q.wdata, s_q.wstrb);
                    s_d.cfg.match = (w[7:0] == 8'h00) ? 8'h01 : w[7:0];
                end
                REG_TRIG_TIME:
                begin
                    w = sts_merge({24'h0, s_q.cfg.trig_ms}, s_q.wdata, s_q.wstrb);
                    s_d.cfg.trig_ms = w[7:0];
                end
                REG_WINDOW:
                begin
                    w = sts_merge({16'h0, s_q.cfg.window_ms}, s_q.wdata, s_q.wstrb);
                    s_d.cfg.window_ms = w[15:0];
                end
                REG_OUT_WIDTH:
                begin
                    w = sts_merge({24'h0, s_q.cfg.out_width}, s_q.wdata, s_q.wstrb);
                    // units of 10 ms, 1..255 gives 10 ms .. 2.55 s
                    s_d.cfg.out_width = (w[7:0] == 8'h00) ? 8'h01 : w[7:0];
                end
                REG_IRQ_MASK:
                begin
                    w = sts_merge({29'h0, s_q.irq_mask}, s_q.wdata, s_q.wstrb);
                    s_d.irq_mask = w[2:0];
                end
                REG_CMD:
                    if (s_q.wstrb[0] && s_q.wdata[0])
                        s_d.lock_ms = 16'(LOCKOUT_MS_P);
                REG_SERIAL:
                begin
                    w = sts_merge({3'h0, s_q.cfg.parity, s_q.cfg.data_bits, s_q.cfg.chars, s_q.cfg.baud_div},
                        s_q.wdata, s_q.wstrb);
                    s_d.cfg.baud_div = w[15:0];
                    s_d.cfg.chars = w[23:16];
                    s_d.cfg.data_bits = w[27:24];
                    s_d.cfg.parity = w[28];
                end
                default:
                    w = '0;
            endcase
        end
        if (s_q.rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            unique case (s_axi_araddr)
                REG_CTRL: rd = {26'h0, s_q.cfg.code_en, s_q.cfg.deferred, s_q.cfg.pulse_mode};
                REG_MATCH: rd = {24'h0, s_q.cfg.match};
                REG_TRIG_TIME: rd = {24'h0, s_q.cfg.trig_ms};
                REG_WINDOW: rd = {16'h0, s_q.cfg.window_ms};
                REG_OUT_WIDTH: rd = {24'h0, s_q.cfg.out_width};
                REG_STATUS: rd = {16'h0, s_q.lock_ms != 16'h0000, s_q.laser, 3'h0, 3'(s_q.state), s_q.hits};
                REG_IRQ_STAT: rd = {29'h0, s_q.irq_stat};
                REG_IRQ_MASK: rd = {29'h0, s_q.irq_mask};
                REG_RESULT: rd = s_q.data;
                REG_TX_TIME: rd = s_q.tx_time;
                REG_SERIAL: rd = {3'h0, s_q.cfg.parity, s_q.cfg.data_bits, s_q.cfg.chars, s_q.cfg.baud_div};
                default: rd = '0;
            endcase
            s_d.rvalid = 1'b1;
            s_d.rdata = rd;
            s_d.rresp = known_addr(s_axi_araddr) ? RESP_OK : RESP_SLVERR;
        end
        // transmit cycles: (data + parity + start/stop) * baud divider * chars
        s_d.tx_time = 32'(({28'h0, s_q.cfg.data_bits} + {31'h0, s_q.cfg.parity} + 32'h0000_0002)
            * {16'h0, s_q.cfg.baud_div} * {24'h0, s_q.cfg.chars});
        // ------------------------------------------------------------
        // read sequence
        // ------------------------------------------------------------
        if (s_q.cyc != 32'h0000_0000)
            s_d.cyc = s_q.cyc - 32'h0000_0001;
        if (ms_tick && s_q.ms != 16'h0000)
            s_d.ms = s_q.ms - 16'h0001;
        unique case (s_q.state)
            IDLE:
                if (trig_go)
                begin
                    s_d.hits = 8'h00;
                    s_d.passed = 1'b0;
                    s_d.data = '0;
                    s_d.by_test = s_q.test_fire;
                    if (s_q.cfg.pulse_mode && !s_q.test_fire)
                    begin
                        s_d.state = ARM;
                        s_d.ms = {8'h0, s_q.cfg.trig_ms} + 16'h0001;
                    end
                    else
                    begin
                        s_d.state = SETTLE;
                        s_d.laser = 1'b1;
                        s_d.cyc = 32'(SETTLE_CYC_P);
                        s_d.ms = s_q.cfg.window_ms;
                    end
                end
            ARM:
                if (!s_q.trig)
                    s_d.state = IDLE;
                else if (s_q.ms == 16'h0000)
                begin
                    s_d.state = SETTLE;
                    s_d.laser = 1'b1;
                    s_d.cyc = 32'(SETTLE_CYC_P);
                    s_d.ms = s_q.cfg.window_ms;
                end
            SETTLE:
                if (s_q.cyc == 32'h0000_0000)
                begin
                    s_d.state = READ;
                    s_d.dec_en = 1'b1;
                end
            READ:
            begin
                if (decode_in.valid && s_q.cfg.code_en[decode_in.code_type])
                begin
                    s_d.hits = s_q.hits + 8'h01;
                    s_d.data = decode_in.data;
                end
                if (s_d.hits >= s_q.cfg.match)
                begin
                    s_d.laser = 1'b0;
                    s_d.dec_en = 1'b0;
                    s_d.passed = 1'b1;
                    s_d.state = s_q.cfg.deferred ? HOLD : DELAY;
                    s_d.cyc = 32'(RESULT_DLY_P) - 32'h0000_0001;
                end
                // a switch press has no level to follow, so it reads for the window
                else if ((!s_q.cfg.pulse_mode && !s_q.by_test && !s_q.trig)
                    || ((s_q.cfg.pulse_mode || s_q.by_test) && s_q.ms == 16'h0000))
                begin
                    s_d.laser = 1'b0;
                    s_d.dec_en = 1'b0;
                    s_d.hits = 8'h00;
                    s_d.data = '0;
                    s_d.state = DELAY;
                    s_d.cyc = 32'(RESULT_DLY_P) - 32'h0000_0001 + 32'(s_q.cfg.trig_ms) * 32'(MS_CYCLES);
                end
                else if (s_q.cfg.pulse_mode)
                    s_d.state = READ;
            end
            HOLD:
                if ((!s_q.cfg.pulse_mode && !s_q.by_test && !s_q.trig)
                    || ((s_q.cfg.pulse_mode || s_q.by_test) && s_q.ms == 16'h0000))
                begin
                    s_d.state = DELAY;
                    s_d.cyc = 32'(RESULT_DLY_P) - 32'h0000_0001;
                end
            DELAY:
                if (s_q.cyc == 32'h0000_0000)
                begin
                    s_d.pass_o = s_q.passed;
                    s_d.fail_o = !s_q.passed;
                    s_d.out_ms = s_q.cfg.out_width;
                    // whole cycles, so the width does not drift with the tick phase
                    s_d.cyc = 32'(OUT_STEP_MS) * 32'(MS_CYCLES) - 32'h0000_0001;
                    s_d.irq_stat[IRQ_PASS] = s_q.irq_stat[IRQ_PASS] | s_q.passed;
                    s_d.irq_stat[IRQ_FAIL] = s_q.irq_stat[IRQ_FAIL] | !s_q.passed;
                    if (s_q.passed && !tx_busy)
                    begin
                        s_d.tx_start = 1'b1;
                        s_d.tx_data = s_q.data;
                        s_d.irq_stat[IRQ_TX] = 1'b1;
                    end
                    s_d.state = SEND;
                end
            SEND:
                if (s_q.cyc == 32'h0000_0000)
                begin
                    s_d.cyc = 32'(OUT_STEP_MS) * 32'(MS_CYCLES) - 32'h0000_0001;
                    s_d.out_ms = s_q.out_ms - 8'h01;
                    if (s_q.out_ms == 8'h01)
                    begin
                        s_d.pass_o = 1'b0;
                        s_d.fail_o = 1'b0;
                        s_d.state = IDLE;
                    end
                end
            default:
                s_d.state = IDLE;
        endcase
        // interrupt status: write one clears, a bit rising from 0 in the same cycle stays set
        if (wr && s_q.awaddr == REG_IRQ_STAT && s_q.wstrb[0])
            s_d.irq_stat = s_d.irq_stat & ~(s_q.wdata[2:0] & ~(s_d.irq_stat & ~s_q.irq_stat));
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
            s_q.state <= IDLE;
            s_q.cfg.match <= RST_MATCH;
            s_q.cfg.trig_ms <= RST_TRIG_TIME;
            s_q.cfg.window_ms <= RST_WINDOW;
            s_q.cfg.out_width <= RST_OUT_WIDTH;
            s_q.cfg.code_en <= RST_CODE_EN;
            s_q.lock_ms <= 16'(LOCKOUT_MS_P);
        end
        else
            s_q <= s_d;
    end

    assign s_axi_awready = !s_q.aw_got;
    assign s_axi_wready = !s_q.w_got;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign laser_on = s_q.laser;
    assign decode_enable = s_q.dec_en;
    assign read_pass_output = s_q.pass_o;
    assign read_fail_output = s_q.fail_o;
    assign tx_start = s_q.tx_start;
    assign tx_data = s_q.tx_data;
    assign irq = s_q.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence laser_rise;
        !laser_on ##1 laser_on;
    endsequence

    a_laser_needs_unlock: assert property (laser_rise |-> s_q.lock_ms == 16'h0000)
        else $error("laser started during lockout");
    a_no_decode_settle: assert property ($rose(laser_on) |-> !decode_enable [*8])
        else $error("decode enabled during gain settling");
    a_laser_off_match: assert property (s_q.state == READ && s_d.hits >= s_q.cfg.match |=> !laser_on)
        else $error("laser not stopped at match count");
    a_level_start: assert property (s_q.state == IDLE && trig_go && !s_q.cfg.pulse_mode |=> laser_on)
        else $error("level trigger did not start laser");
    a_pulse_arm: assert property (s_q.state == IDLE && trig_go && s_q.cfg.pulse_mode && !s_q.test_fire
        |=> !laser_on)
        else $error("pulse trigger fired laser early");
    a_result_excl: assert property (!(read_pass_output && read_fail_output))
        else $error("pass and fail both active");
    a_fail_on_drop: assert property (s_q.state == READ && !s_q.cfg.pulse_mode && !trig_src
        && !s_q.by_test && s_d.hits < s_q.cfg.match |=> s_q.state == DELAY && !s_q.passed)
        else $error("early release not failed");
    a_out_width: assert property ($rose(read_pass_output | read_fail_output) |-> s_q.out_ms == s_q.cfg.out_width
        && s_q.out_ms != 8'h00)
        else $error("result width not loaded");
    a_fail_delay: assert property (s_q.state == READ && s_d.state == DELAY && !s_d.passed
        |=> s_q.cyc == 32'(RESULT_DLY_P) - 32'h0000_0001 + 32'($past(s_q.cfg.trig_ms)) * 32'(MS_CYCLES))
        else $error("fail delay too short");
    a_single_hit: assert property (s_q.state != READ && s_q.state != IDLE |=> $stable(s_q.data))
        else $error("data changed outside read");
endmodule

// [tb/sts_decoder_model.sv]
// decoder model: offers up to hits decodes while decode_enable is high
// assumes the bench sets hits and data before each trigger
`timescale 1ns/1ns
module sts_decoder_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic decode_enable,
    input wire logic [3:0] hits,
    input wire logic [31:0] data,
    output sts_pkg::sts_decode_t decode_in
);
    import sts_pkg::*;
    logic [3:0] left_q;
    logic [1:0] gap_q;
    // idle data toggles each cycle so a stale word is never mistaken for a result
    always @(posedge aclk)
    begin
        gap_q <= gap_q + 2'd1;
        decode_in <= '{1'b0, gap_q, ~decode_in.data};
        if (!aresetn)
        begin
            gap_q <= 2'd0;
            left_q <= 4'd0;
            decode_in <= '0;
        end
        else if (!decode_enable)
            left_q <= hits;
        else if (left_q != 4'd0 && gap_q == 2'd0)
        begin
            left_q <= left_q - 4'd1;
            decode_in <= '{1'b1, 2'd0, data};
        end
    end
endmodule

// [tb/test_scan_trigger_sequencer.sv]
// bench: axi tasks, level and pulse reads, scoreboard queues
// assumes shortened ms, lockout, settle and result-delay parameters
`timescale 1ns/1ns
module test_scan_trigger_sequencer;
    import sts_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, trigger_in = 1'b0, test_switch_n = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, tx_data, lfsr_q = 32'h0000_9eca, d;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic laser_on, decode_enable, read_pass_output, read_fail_output, tx_start, irq;
    logic [3:0] hits = 4'd0;
    logic tx_busy = 1'b0;
    sts_decode_t decode_in;
    logic [33:0] exp_q[$];
    logic [31:0] tx_q[$];
    int miscompares = 0, checked = 0, cycles = 0, n;
    wire [2:0] mon = {read_fail_output, read_pass_output, laser_on};
    sts_sequencer #(.MS_CYCLES(10), .LOCKOUT_MS_P(2), .SETTLE_CYC_P(20), .RESULT_DLY_P(10)) dut_u (
        .s_axi_wstrb(4'hf), .*);
    sts_decoder_model model_u (.aclk(aclk), .aresetn(aresetn), .decode_enable(decode_enable), .hits(hits),
        .data(lfsr_q), .decode_in(decode_in));
    initial forever #5 aclk = ~aclk;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        exp_q.push_back({r, 32'h0000_0000});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    task automatic wait_lvl(input int k, input logic v);
        n = 0;
        while (mon[k] !== v)
        begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic locked;
        trigger_in <= 1'b1;
        repeat (10) @(posedge aclk);
        chk(laser_on, 1'b0);
        trigger_in <= 1'b0;
        repeat (40) @(posedge aclk);
    endtask
    // --------------------------------
    // watcher: timeout and scoreboard
    // --------------------------------
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            wrap_up();
        end
        if (s_axi_bvalid && s_axi_bready)
            chk({s_axi_bresp, 32'h0000_0000}, exp_q.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        if (tx_start)
            chk(tx_data, tx_q.pop_front());
    end
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        locked();
        rd(REG_MATCH, {RESP_OK, 32'h0000_0001});
        rd(8'hFC, {RESP_SLVERR, 32'h0000_0000});
        wr(REG_OUT_WIDTH, 32'h0000_0001, RESP_OK);
        wr(REG_MATCH, 32'h0000_0002, RESP_OK);
        wr(REG_IRQ_MASK, 32'h0000_0003, RESP_OK);
        // pass 0 level, pass 1 pulse; three decodes offered, two wanted
        for (int m = 0; m < 2; m++)
        begin
            d = lfsr(lfsr_q);
            tx_q.push_back(d);
            lfsr_q <= d;
            hits <= 4'd3;
            trigger_in <= 1'b1;
            repeat (15) @(posedge aclk);
            chk(laser_on, m == 0);
            chk(decode_enable, 1'b0);
            wait_lvl(0, 1'b1);
            wait_lvl(0, 1'b0);
            wait_lvl(1, 1'b1);
            chk(n >= 8 && n <= 13, 1'b1);
            chk(irq, 1'b1);
            wait_lvl(1, 1'b0);
            chk(n >= 98 && n <= 102, 1'b1);
            trigger_in <= 1'b0;
            wr(REG_IRQ_STAT, 32'h0000_0007, RESP_OK);
            chk(irq, 1'b0);
            wr(REG_CTRL, 32'h0000_0005, RESP_OK);
        end
        // switch press, deferred output, transmitter busy: no transmission, result after the window
        wr(REG_CTRL, 32'h0000_0006, RESP_OK);
        tx_busy <= 1'b1;
        test_switch_n <= 1'b0;
        repeat (8) @(posedge aclk);
        test_switch_n <= 1'b1;
        repeat (10) @(posedge aclk);
        chk(laser_on, 1'b1);
        wait_lvl(0, 1'b0);
        wait_lvl(1, 1'b1);
        chk(n > 900 && n < 1100, 1'b1);
        wait_lvl(1, 1'b0);
        wr(REG_CTRL, 32'h0000_0004, RESP_OK);
        wr(REG_IRQ_MASK, 32'h0000_0000, RESP_OK);
        wr(REG_CMD, 32'h0000_0001, RESP_OK);
        locked();
        hits <= 4'd0;
        trigger_in <= 1'b1;
        repeat (40) @(posedge aclk);
        trigger_in <= 1'b0;
        wait_lvl(2, 1'b1);
        chk(n >= 30 && n <= 36, 1'b1);
        chk({laser_on, irq}, 2'b00);
        rd(REG_IRQ_STAT, {RESP_OK, 32'h0000_0003});
        wrap_up();
    end
endmodule
